// *** src/converter_fault_supervisor.sv ***
// converter fault supervisor: thermal, overpower, short-circuit response
// Functional notes
// - fault pin low past filter raises thermal fault
// - after thermal fault, clear needs higher threshold
// - fault pin bias off during burst wait
// - divider option uses 750us, ignores wait, auto-only
// - two successive high current-sense samples trip thermal
// - current-sense thermal fault starts long recovery
// - clamp gate low throughout low-side on-time
// - overpower timer starts when command exceeds level
// - full uninterrupted overpower period stops switching, recovers
// - line compensation current is line current over gain
// - curve select with 2.5/2.4 hysteresis
// - top of overpower curve is 0.6 V
// - peak clamp fixed at 4/3 overpower level
// - at supply turn-off, short checks start recovery
// - otherwise plain undervoltage restart only
// - during recovery only supply cycling, no pulses
// - after recovery, restart at next supply turn-off
`timescale 1ns/100ps
`default_nettype none
module converter_fault_supervisor
    import fault_sup_pkg::*;
#(
    parameter int unsigned FILTER_CYCLES = THERMAL_FILTER_CYC,
    parameter int unsigned DIV_CYCLES = DIVIDER_OTP_CYC,
    parameter int unsigned OPP_CYCLES = OVERPOWER_CYC,
    parameter int unsigned RECOVERY_CYCLES = RECOVERY_CYC,
    parameter int LC_W = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq_o,
    // converter side
    input wire sense_s sense_i,
    input wire logic burst_wait_i,
    input wire logic demag_end_i,
    input wire logic supply_off_i,
    input wire logic gate_req_i,
    input wire logic clamp_req_i,
    input wire logic [LC_W-1:0] line_sense_current_i,
    input wire logic [LC_W-1:0] line_comp_gain_i,
    output logic low_side_gate_out_o,
    output logic clamp_side_gate_out_o,
    output logic run_enable_o,
    output logic flt_bias_en_o,
    output logic high_curve_sel_o,
    output logic flt_high_thr_o,
    output logic [LC_W-1:0] line_comp_current_o
);
    logic [2:0] ctrl_r;
    logic [EV_W-1:0] stat_r;
    logic [EV_W-1:0] mask_r;
    logic [EV_W-1:0] ev;
    sup_state_e state_r;
    logic [CNT_W-1:0] flt_cnt_r;
    logic [CNT_W-1:0] div_cnt_r;
    logic [CNT_W-1:0] opp_cnt_r;
    logic [CNT_W-1:0] rec_cnt_r;
    logic [1:0] cs_hits_r;
    logic flt_latched_r;
    logic running;
    logic auto_mode;
    logic trip_flt;
    logic trip_div;
    logic trip_cs;
    logic trip_opp;
    logic trip_scp;
    logic start_rec;
    logic rec_done;
    logic bus_req;
    logic rd_stat;

    assign auto_mode = ctrl_r[CTRL_AUTO_BIT] | ctrl_r[CTRL_DIV_BIT];
    assign running = (state_r == ST_RUN);
    assign bus_req = cyc_i & stb_i & ~ack_o;
    assign rd_stat = bus_req & ~we_i & (adr_i == IRQ_STAT_OFS);

    // wishbone ack one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= bus_req;
        end
    end

    // control and mask registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= CTRL_RST;
            mask_r <= '0;
        end else if (bus_req && we_i && sel_i[0]) begin
            if (adr_i == CTRL_OFS) begin
                ctrl_r <= dat_i[2:0];
            end
            if (adr_i == IRQ_MASK_OFS) begin
                mask_r <= dat_i[EV_W-1:0];
            end
        end
    end

    // read data mux, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= '0;
        end else if (bus_req && !we_i) begin
            case (adr_i)
                CTRL_OFS: dat_o <= {29'h0, ctrl_r};
                STATE_OFS: dat_o <= {28'h0, flt_latched_r, 1'b0,
                                     2'(state_r)};
                IRQ_STAT_OFS: dat_o <= {27'h0, stat_r};
                IRQ_MASK_OFS: dat_o <= {27'h0, mask_r};
                default: dat_o <= '0;
            endcase
        end
    end

    // sticky status, set wins over read clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_r <= '0;
        end else begin
            stat_r <= (rd_stat ? '0 : stat_r) | ev;
        end
    end
    assign irq_o = |(stat_r & mask_r);

    // fault pin thermal filter with raised release threshold
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flt_cnt_r <= '0;
        end else if (!ctrl_r[CTRL_DIV_BIT] && running && !burst_wait_i
                     && sense_i.flt_below_trip) begin
            if (flt_cnt_r < FILTER_CYCLES) begin
                flt_cnt_r <= flt_cnt_r + 1'b1;
            end
        end else begin
            flt_cnt_r <= '0;
        end
    end
    assign trip_flt = running && (flt_cnt_r == FILTER_CYCLES);

    // divider option: 750us above 4.5 V, counts regardless of wait
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt_r <= '0;
        end else if (ctrl_r[CTRL_DIV_BIT] && running
                     && sense_i.flt_above_iovp) begin
            if (div_cnt_r < DIV_CYCLES) begin
                div_cnt_r <= div_cnt_r + 1'b1;
            end
        end else begin
            div_cnt_r <= '0;
        end
    end
    assign trip_div = running && (div_cnt_r == DIV_CYCLES);

    // thermal latch held until pin rises above the high threshold
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flt_latched_r <= 1'b0;
        end else if (trip_flt && auto_mode) begin
            flt_latched_r <= 1'b1;
        end else if (!sense_i.flt_below_high) begin
            flt_latched_r <= 1'b0;
        end
    end
    assign flt_high_thr_o = flt_latched_r;
    // bias stays on while latched so the release level can be seen
    assign flt_bias_en_o = (running | flt_latched_r) & ~burst_wait_i
                         & ~ctrl_r[CTRL_DIV_BIT];

    // current sense thermal: sample at demag end, two in a row
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cs_hits_r <= '0;
        end else if (!running || !ctrl_r[CTRL_CSOTP_BIT]) begin
            cs_hits_r <= '0;
        end else if (demag_end_i) begin
            if (!sense_i.cs_above_otp) begin
                cs_hits_r <= '0;
            end else if (cs_hits_r < 2'(CS_OTP_COUNT)) begin
                cs_hits_r <= cs_hits_r + 1'b1;
            end
        end
    end
    assign trip_cs = running && (cs_hits_r == 2'(CS_OTP_COUNT));

    // overpower timer, cleared when command drops back
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opp_cnt_r <= '0;
        end else if (running && sense_i.cmd_above_opp) begin
            if (opp_cnt_r < OPP_CYCLES) begin
                opp_cnt_r <= opp_cnt_r + 1'b1;
            end
        end else begin
            opp_cnt_r <= '0;
        end
    end
    assign trip_opp = running && (opp_cnt_r == OPP_CYCLES);

    // short-circuit check at supply turn-off
    assign trip_scp = running && supply_off_i && auto_mode
        && (sense_i.cmd_above_opp || sense_i.ws_below_short);

    assign start_rec = auto_mode && (trip_cs || trip_opp || trip_div
                                     || trip_scp);
    assign rec_done = (state_r == ST_RECOVERY)
                      && (rec_cnt_r == RECOVERY_CYCLES - 1);

    // fault state sequencing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_RUN;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (start_rec) begin
                        state_r <= ST_RECOVERY;
                    end else if (trip_flt || supply_off_i) begin
                        state_r <= ST_UV_CYCLE;
                    end
                end
                ST_UV_CYCLE: begin
                    if (!supply_off_i && !flt_latched_r) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_RECOVERY: begin
                    if (rec_done) begin
                        state_r <= ST_WAIT_UV;
                    end
                end
                ST_WAIT_UV: begin
                    if (supply_off_i) begin
                        state_r <= ST_UV_CYCLE;
                    end
                end
                default: state_r <= ST_RUN;
            endcase
        end
    end

    // long recovery timer
    always_ff @(posedge clk_i) begin
        if (rst_i || state_r != ST_RECOVERY) begin
            rec_cnt_r <= '0;
        end else begin
            rec_cnt_r <= rec_cnt_r + 1'b1;
        end
    end

    // events into the sticky status
    always_comb begin
        ev = '0;
        ev[EV_FLT_OTP] = trip_flt | trip_div;
        ev[EV_CS_OTP] = trip_cs;
        ev[EV_OPP] = trip_opp;
        ev[EV_SCP] = trip_scp;
        ev[EV_RECOVERED] = rec_done;
    end

    // gate outputs: clamp never overlaps low-side on-time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_side_gate_out_o <= 1'b0;
            clamp_side_gate_out_o <= 1'b0;
            run_enable_o <= 1'b0;
        end else begin
            low_side_gate_out_o <= running & ~start_rec & gate_req_i;
            clamp_side_gate_out_o <= running & ~start_rec & clamp_req_i
                                     & ~gate_req_i;
            run_enable_o <= running & ~start_rec;
        end
    end

    // overpower curve select with hysteresis
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_curve_sel_o <= 1'b1;
        end else if (sense_i.ws_above_upper) begin
            high_curve_sel_o <= 1'b1;
        end else if (sense_i.ws_below_lower) begin
            high_curve_sel_o <= 1'b0;
        end
    end

    // line compensation current command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_comp_current_o <= '0;
        end else if (line_comp_gain_i != '0) begin
            line_comp_current_o <= line_sense_current_i
                                   / line_comp_gain_i;
        end
    end

    AST_OPP_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        !sense_i.cmd_above_opp |=> opp_cnt_r == '0)
        else $error("overpower timer not cleared");
    AST_OPP_TRIP: assert property (@(posedge clk_i) disable iff (rst_i)
        trip_opp && auto_mode |=> state_r == ST_RECOVERY)
        else $error("overpower did not start recovery");
    AST_CS_TRIP: assert property (@(posedge clk_i) disable iff (rst_i)
        trip_cs && auto_mode |=> state_r == ST_RECOVERY)
        else $error("cs thermal did not start recovery");
    AST_CLAMP_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
        low_side_gate_out_o |-> !clamp_side_gate_out_o)
        else $error("clamp gate overlaps low gate");
    AST_NO_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        state_r == ST_RECOVERY |=> !low_side_gate_out_o)
        else $error("gate pulse during recovery");
    AST_BIAS_WAIT: assert property (@(posedge clk_i) disable iff (rst_i)
        burst_wait_i |-> !flt_bias_en_o)
        else $error("bias on in wait");
    AST_SCP: assert property (@(posedge clk_i) disable iff (rst_i)
        trip_scp |=> state_r == ST_RECOVERY)
        else $error("short did not start recovery");
    AST_UV_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
        running && supply_off_i && !start_rec |=> state_r == ST_UV_CYCLE)
        else $error("plain restart missed");
    AST_FLT_TRIP: assert property (@(posedge clk_i) disable iff (rst_i)
        trip_flt && auto_mode |=> flt_high_thr_o)
        else $error("high threshold not raised");
    AST_RESTART: assert property (@(posedge clk_i) disable iff (rst_i)
        state_r == ST_WAIT_UV && supply_off_i |=> state_r == ST_UV_CYCLE)
        else $error("no restart after recovery");
endmodule : converter_fault_supervisor
`default_nettype wire

// *** common/fault_sup_pkg.sv ***
// package: constants and carrier types for the converter fault supervisor
package fault_sup_pkg;
    localparam int CLK_MHZ = 200;
    // timing figures in their own units
    localparam int THERMAL_FILTER_US = 50;
    localparam int DIVIDER_OTP_US = 750;
    localparam int OVERPOWER_MS = 160;
    localparam int RECOVERY_MS = 1500;
    localparam int THERMAL_FILTER_CYC = THERMAL_FILTER_US * CLK_MHZ;
    localparam int DIVIDER_OTP_CYC = DIVIDER_OTP_US * CLK_MHZ;
    localparam int OVERPOWER_CYC = OVERPOWER_MS * 1000 * CLK_MHZ;
    localparam int RECOVERY_CYC = RECOVERY_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 32;
    localparam int CS_OTP_COUNT = 2;
    // wishbone register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATE_OFS = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
    // control field positions
    localparam int CTRL_AUTO_BIT = 0;
    localparam int CTRL_DIV_BIT = 1;
    localparam int CTRL_CSOTP_BIT = 2;
    localparam logic [2:0] CTRL_RST = 3'h1;
    // event bit positions
    localparam int EV_FLT_OTP = 0;
    localparam int EV_CS_OTP = 1;
    localparam int EV_OPP = 2;
    localparam int EV_SCP = 3;
    localparam int EV_RECOVERED = 4;
    localparam int EV_W = 5;

    typedef enum logic [1:0] {ST_RUN, ST_UV_CYCLE, ST_RECOVERY, ST_WAIT_UV}
        sup_state_e;

    // comparator results from the analog sense front end
    typedef struct packed {
        logic flt_below_trip;   // fault pin below 0.5 V trip
        logic flt_below_high;   // fault pin below 1.15 V raised trip
        logic flt_above_iovp;   // fault pin above 4.5 V
        logic cs_above_otp;     // current sense above 1.2 V
        logic cmd_above_opp;    // command above overpower level
        logic ws_above_upper;   // winding sense above 2.5 V
        logic ws_below_lower;   // winding sense below 2.4 V
        logic ws_below_short;   // winding sense below 0.5 V
    } sense_s;
endpackage : fault_sup_pkg

// *** dv/flyback_stage_model.sv ***
// partner model: flyback stage, thermistor and sense network
`timescale 1ns/100ps
`default_nettype none
module flyback_stage_model
    import fault_sup_pkg::*;
(
    input wire logic clk_i,
    input wire logic gate_i,
    input wire logic run_i,
    input wire logic bias_i,
    input wire logic [7:0] knob_i,
    output var sense_s sense_o,
    output logic demag_end_o
);
    logic gate_d;

    // demag ends one edge after the low-side gate falls
    always_ff @(posedge clk_i) begin
        gate_d <= gate_i;
    end
    assign demag_end_o = gate_d & ~gate_i;

    // knobs: hot, warm, iovp, cs hot, cmd high, ws high, ws low, ws short
    // unbiased fault pin sits at ground and reads below both levels
    // cs sensor biased by run, seen only while low gate is off
    always_comb begin
        sense_o.flt_below_trip = knob_i[0] | ~bias_i;
        sense_o.flt_below_high = knob_i[0] | knob_i[1] | ~bias_i;
        sense_o.flt_above_iovp = knob_i[2];
        sense_o.cs_above_otp = knob_i[3] & run_i & ~gate_i;
        sense_o.cmd_above_opp = knob_i[4];
        sense_o.ws_above_upper = knob_i[5];
        sense_o.ws_below_lower = knob_i[6];
        sense_o.ws_below_short = knob_i[7];
    end
endmodule : flyback_stage_model
`default_nettype wire

// *** dv/converter_fault_supervisor_tb_top.sv ***
// testbench for the converter fault supervisor
`timescale 1ns/100ps
`default_nettype none
module converter_fault_supervisor_tb_top
    import fault_sup_pkg::*;
;
    logic clk, rst, cyc, stb, we, ack, irq, bw, dme, so, greq, creq;
    logic lo, cl, run, bias, hcs, fht;
    logic [7:0] adr, knob;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [11:0] line, gain, lcc;
    sense_s sense;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc_cnt = 0;

    converter_fault_supervisor #(.FILTER_CYCLES(20), .DIV_CYCLES(30),
        .OPP_CYCLES(50), .RECOVERY_CYCLES(100)) dut (
        .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
        .ack_o(ack), .irq_o(irq), .sense_i(sense), .burst_wait_i(bw),
        .demag_end_i(dme), .supply_off_i(so), .gate_req_i(greq),
        .clamp_req_i(creq), .line_sense_current_i(line),
        .line_comp_gain_i(gain), .low_side_gate_out_o(lo),
        .clamp_side_gate_out_o(cl), .run_enable_o(run),
        .flt_bias_en_o(bias), .high_curve_sel_o(hcs),
        .flt_high_thr_o(fht), .line_comp_current_o(lcc));

    flyback_stage_model stage (.clk_i(clk), .gate_i(lo), .run_i(run),
        .bias_i(bias), .knob_i(knob), .sense_o(sense), .demag_end_o(dme));

    // clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // cut a hang short
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 6000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    // one classic wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        @(posedge clk);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        q = rdat;
        chk("bus ack", 1'h1, ack);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, 4'hF, q);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, 4'hF, q);
    endtask : wr

    // supply reaches turn-off for three cycles
    task automatic sup(input int n);
        so <= 1'b1;
        repeat (3) @(posedge clk);
        so <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : sup

    // walk the long recovery back to running
    task automatic recover();
        logic [31:0] q;
        greq <= 1'b1;
        repeat (80) begin
            @(posedge clk);
            chk("gate in recovery", 1'h0, lo);
        end
        rd(STATE_OFS, q);
        chk("recovering", ST_RECOVERY, q[1:0]);
        repeat (40) @(posedge clk);
        rd(STATE_OFS, q);
        chk("wait supply", ST_WAIT_UV, q[1:0]);
        sup(5);
        rd(STATE_OFS, q);
        chk("restart", ST_RUN, q[1:0]);
        greq <= 1'b0;
    endtask : recover

    task automatic t_reset();
        logic [31:0] q;
        chk("curve reset", 1'h1, hcs);
        rd(CTRL_OFS, q);
        chk("ctrl reset", CTRL_RST, q);
        rd(STATE_OFS, q);
        chk("state reset", 32'h0, q);
        wb(1'b1, IRQ_MASK_OFS, 32'h1F, 4'h0, q);
        rd(IRQ_MASK_OFS, q);
        chk("mask no sel", 32'h0, q);
        wr(8'h10, 32'hFF);
        rd(8'h10, q);
        chk("unmapped", 32'h0, q);
    endtask : t_reset

    task automatic t_line();
        line <= 12'h258;
        gain <= 12'h005;
        repeat (3) @(posedge clk);
        chk("comp", 32'h78, lcc);
        gain <= 12'h000;
        repeat (3) @(posedge clk);
        chk("comp hold", 32'h78, lcc);
        knob <= 8'h40;
        repeat (2) @(posedge clk);
        chk("low curve", 1'h0, hcs);
        knob <= 8'h00;
        repeat (2) @(posedge clk);
        chk("curve hold", 1'h0, hcs);
        knob <= 8'h20;
        repeat (2) @(posedge clk);
        chk("high curve", 1'h1, hcs);
        knob <= 8'h00;
    endtask : t_line

    task automatic t_wait();
        bw <= 1'b1;
        knob <= 8'h01;
        repeat (30) @(posedge clk);
        chk("bias in wait", 1'h0, bias);
        chk("no trip in wait", 1'h1, run);
        bw <= 1'b0;
        knob <= 8'h00;
        @(posedge clk);
        chk("bias on", 1'h1, bias);
    endtask : t_wait

    task automatic t_flt();
        logic [31:0] q;
        knob <= 8'h01;
        repeat (19) @(posedge clk);
        knob <= 8'h00;
        rd(IRQ_STAT_OFS, q);
        chk("early trip", 32'h0, q);
        knob <= 8'h01;
        repeat (24) @(posedge clk);
        chk("run after trip", 1'h0, run);
        chk("raised thr", 1'h1, fht);
        chk("masked irq", 1'h0, irq);
        wr(IRQ_MASK_OFS, 32'h1F);
        chk("irq", 1'h1, irq);
        rd(IRQ_STAT_OFS, q);
        chk("status", 32'h1, q);
        chk("irq cleared", 1'h0, irq);
        knob <= 8'h02;
        sup(120);
        sup(20);
        chk("held warm", 1'h0, run);
        knob <= 8'h00;
        sup(20);
        chk("cool run", 1'h1, run);
        chk("thr back", 1'h0, fht);
    endtask : t_flt

    task automatic t_cs();
        logic [31:0] q;
        wr(CTRL_OFS, 32'h5);
        creq <= 1'b1;
        greq <= 1'b1;
        knob <= 8'h08;
        repeat (2) @(posedge clk);
        chk("clamp in on", 1'h0, cl);
        greq <= 1'b0;
        repeat (3) @(posedge clk);
        chk("clamp off", 1'h1, cl);
        rd(IRQ_STAT_OFS, q);
        chk("one sample", 1'h0, q[EV_CS_OTP]);
        greq <= 1'b1;
        repeat (2) @(posedge clk);
        greq <= 1'b0;
        repeat (4) @(posedge clk);
        chk("cs run", 1'h0, run);
        rd(IRQ_STAT_OFS, q);
        chk("cs event", 1'h1, q[EV_CS_OTP]);
        knob <= 8'h00;
        recover();
        rd(IRQ_STAT_OFS, q);
        chk("recovered", 1'h1, q[EV_RECOVERED]);
    endtask : t_cs

    task automatic t_opp();
        logic [31:0] q;
        wr(CTRL_OFS, 32'h1);
        knob <= 8'h10;
        repeat (49) @(posedge clk);
        knob <= 8'h00;
        rd(IRQ_STAT_OFS, q);
        chk("opp cleared", 1'h0, q[EV_OPP]);
        knob <= 8'h10;
        repeat (53) @(posedge clk);
        chk("opp run", 1'h0, run);
        rd(IRQ_STAT_OFS, q);
        chk("opp event", 1'h1, q[EV_OPP]);
        knob <= 8'h00;
        recover();
    endtask : t_opp

    task automatic t_scp();
        logic [31:0] q;
        logic [7:0] k[2] = '{8'h10, 8'h80};
        foreach (k[i]) begin
            knob <= k[i];
            repeat (5) @(posedge clk);
            sup(3);
            rd(STATE_OFS, q);
            chk("short state", ST_RECOVERY, q[1:0]);
            rd(IRQ_STAT_OFS, q);
            chk("short event", 1'h1, q[EV_SCP]);
            knob <= 8'h00;
            recover();
        end
        so <= 1'b1;
        repeat (2) @(posedge clk);
        rd(STATE_OFS, q);
        chk("plain uv", ST_UV_CYCLE, q[1:0]);
        so <= 1'b0;
        repeat (3) @(posedge clk);
        rd(IRQ_STAT_OFS, q);
        chk("no short", 32'h0, q[3:2]);
        chk("uv run", 1'h1, run);
    endtask : t_scp

    task automatic t_div();
        logic [31:0] q;
        wr(CTRL_OFS, 32'h2);
        bw <= 1'b1;
        knob <= 8'h04;
        repeat (29) @(posedge clk);
        knob <= 8'h00;
        rd(IRQ_STAT_OFS, q);
        chk("div early", 1'h0, q[EV_FLT_OTP]);
        knob <= 8'h04;
        repeat (33) @(posedge clk);
        chk("div run", 1'h0, run);
        rd(IRQ_STAT_OFS, q);
        chk("div event", 1'h1, q[EV_FLT_OTP]);
        bw <= 1'b0;
        knob <= 8'h00;
        recover();
    endtask : t_div

    // manual mode: faults other than the fault-pin thermal trip only flag, no long recovery, no short check
    task automatic t_manual();
        logic [31:0] q;
        wr(CTRL_OFS, 32'h0);
        knob <= 8'h10;
        repeat (53) @(posedge clk);
        chk("manual run", 1'h1, run);
        rd(IRQ_STAT_OFS, q);
        chk("manual opp", 1'h1, q[EV_OPP]);
        so <= 1'b1;
        repeat (2) @(posedge clk);
        rd(STATE_OFS, q);
        chk("manual uv", ST_UV_CYCLE, q[1:0]);
        so <= 1'b0;
        knob <= 8'h00;
        repeat (3) @(posedge clk);
        rd(IRQ_STAT_OFS, q);
        chk("manual no short", 1'h0, q[EV_SCP]);
        chk("manual back", 1'h1, run);
    endtask : t_manual

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // main sequence
    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
        knob = 8'h00;
        bw = 1'b0;
        so = 1'b0;
        greq = 1'b0;
        creq = 1'b0;
        line = 12'h000;
        gain = 12'h001;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_line();
        t_wait();
        t_flt();
        t_cs();
        t_opp();
        t_scp();
        t_div();
        t_manual();
        tally_and_finish();
    end
endmodule : converter_fault_supervisor_tb_top
`default_nettype wire
